//--- design/tup_ov_window.sv
// Overvoltage pulldown of the thermistor line with periodic release window
`timescale 1ns/1ps
module tup_ov_window #(
  parameter int unsigned PER = tup_pkg::PER_CYC,
  parameter int unsigned REL = tup_pkg::REL_CYC
) (
  input  wire logic hclk,     // System clock
  input  wire logic hresetn,  // Async reset, active low
  input  wire logic req,      // Pulldown wanted
  output logic      pull_r    // Line pulled to ground
);
  import tup_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             pull_nxt;

  always_comb begin
    cnt_nxt  = '0;
    pull_nxt = 1'b0;
    if (req) begin
      cnt_nxt  = (cnt_r == CNT_W'(PER - 1)) ? '0 : cnt_r + 1'b1;
      pull_nxt = cnt_nxt < CNT_W'(PER - REL);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r  <= '0;
      pull_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      pull_r <= pull_nxt;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_OV_RELEASE: assert property (req && cnt_r >= CNT_W'(PER - REL) |-> !pull_r)
    else $error("pulldown held in release window");
  AST_OV_PULL: assert property (req && cnt_r < CNT_W'(PER - REL) && $past(req) |-> pull_r)
    else $error("pulldown missing outside window");
  COV_OV_REL: cover property (pull_r ##1 !pull_r && req);
endmodule

//--- design/tup_pkg.sv
// Shared constants and types for the thermistor and undervoltage protection block
package tup_pkg;
  // Clock rate and documented times
  localparam int unsigned CLK_MHZ    = 125;
  localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
  localparam int unsigned T_REL_MS   = 200;
  localparam int unsigned T_PER_MS   = 4000;
  localparam int unsigned T_UVSD_MS  = 8000;
  localparam int unsigned T_CHK_MS   = 1;
  localparam int unsigned REL_CYC    = T_REL_MS * CYC_PER_MS;
  localparam int unsigned PER_CYC    = T_PER_MS * CYC_PER_MS;
  localparam int unsigned UVSD_CYC   = T_UVSD_MS * CYC_PER_MS;
  localparam int unsigned CHK_CYC    = T_CHK_MS * CYC_PER_MS;
  localparam int unsigned SETTLE_CYC = 16;
  localparam int unsigned CNT_W      = 30;
  // Register map, byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_UVDLY = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  // Control bit positions
  localparam int unsigned CB_OVTS  = 0;
  localparam int unsigned CB_TMDIS = 1;
  localparam int unsigned CB_UVREC = 2;
  localparam int unsigned CB_UVSD  = 3;
  localparam logic [3:0]  CTRL_RST  = 4'h0;
  localparam logic [31:0] UVDLY_RST = 32'h0000_0400;
  // Thermistor fault and check sequence
  typedef enum logic [1:0] {TF_NONE, TF_HOT, TF_OPEN, TF_SHORT} tup_tfault_t;
  typedef enum logic [1:0] {CK_IDLE, CK_SINK, CK_BIAS, CK_EVAL} tup_chk_t;
endpackage

//--- design/tup_protect.sv
// Thermistor fault, overvoltage signalling and undervoltage shutdown logic
`timescale 1ns/1ps
module tup_protect #(
  parameter int unsigned CHK = tup_pkg::CHK_CYC,
  parameter int unsigned PER = tup_pkg::PER_CYC,
  parameter int unsigned REL = tup_pkg::REL_CYC,
  parameter int unsigned UVSD = tup_pkg::UVSD_CYC
) (
  input  wire logic        hclk,             // Clock
  input  wire logic        hresetn,          // Async reset, low
  input  wire logic        hsel,             // Slave select
  input  wire logic [7:0]  haddr,            // Byte address
  input  wire logic [1:0]  htrans,           // Transfer type
  input  wire logic        hwrite,           // Write
  input  wire logic [2:0]  hsize,            // Word only
  input  wire logic [31:0] hwdata,           // Write data
  input  wire logic        hready,           // Bus ready
  output logic             hreadyout,        // Always ready
  output logic [31:0]      hrdata,           // Read data
  output logic             hresp,            // Always OKAY
  input  wire logic        ts_above_ext_pu,  // Sense above external pullup
  input  wire logic        ts_below_hot,     // Sense below overtemp
  input  wire logic        ts_above_open,    // Sense at open level
  input  wire logic        ts_below_short,   // Sense at short level
  input  wire logic        charger_sense_in, // Charger comparator
  input  wire logic        discharge_pack_neg_sense_below_2v,   // Discharge pack negative low
  input  wire logic        cell_uv_any,      // A cell below threshold
  input  wire logic        cells_above_hyst, // All cells above hyst
  input  wire logic        cells_below_hyst, // All cells below hyst
  input  wire logic        ov_fault,         // Overvoltage present
  output logic             ts_weak_sink_en,  // Weak sink on sense pin
  output logic             thermistor_bias_out, // Own bias
  output logic             thermistor_sense_o,  // Sense pin drive
  output logic             thermistor_sense_oe, // Sense pin enable
  output logic             charger_detected,    // Charger present
  output logic             load_removed,        // Load gone
  output logic             regulator_output_en, // Regulator enable
  output logic             discharge_gate_drive, // Discharge gate
  output logic             charge_gate_drive,    // Charge gate
  output logic             shutdown              // Shutdown state
);
  import tup_pkg::*;

  // Bus state
  logic        dp_wr_r, dp_wr_nxt;
  logic [7:0]  dp_adr_r, dp_adr_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [3:0]  ctrl_r, ctrl_nxt;
  logic [31:0] uvdly_r, uvdly_nxt;
  logic        take;
  logic [31:0] stat;

  // Thermistor check state
  tup_chk_t         ck_r, ck_nxt;
  tup_tfault_t      tf_r, tf_nxt;
  logic [CNT_W-1:0] ck_cnt_r, ck_cnt_nxt;
  logic             ext_r, ext_nxt;

  // Undervoltage and power state
  logic [31:0]      uv_cnt_r, uv_cnt_nxt;
  logic [CNT_W-1:0] sd_cnt_r, sd_cnt_nxt;
  logic             uv_r, uv_nxt;
  logic             sd_r, sd_nxt;
  logic             reg_r, reg_nxt;
  logic             dsg_r, dsg_nxt;
  logic             chg_r, chg_nxt;
  logic             lr_r, cd_r;
  logic             pull;
  logic             short_hit, uvsd_hit;

  wire ovts  = ctrl_r[CB_OVTS];
  wire tmdis = ctrl_r[CB_TMDIS];
  wire uvrec = ctrl_r[CB_UVREC];
  wire uvsd  = ctrl_r[CB_UVSD];

  // Register read mux
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [31:0] s);
    logic [31:0] v;
    v = '0;
    unique case (a)
      OFS_CTRL:  v = {28'h0, ctrl_r};
      OFS_UVDLY: v = uvdly_r;
      OFS_STAT:  v = s;
      default:   v = '0;
    endcase
    return v;
  endfunction

  assign stat = {24'h0, cd_r, pull, ext_r, lr_r, sd_r, uv_r, tf_r};
  assign take = hsel && hready && htrans[1];

  // Bus slave: zero wait, read data captured at address phase
  always_comb begin
    dp_wr_nxt  = take && hwrite;
    dp_adr_nxt = take ? haddr : dp_adr_r;
    rdat_nxt   = (take && !hwrite) ? rd_mux(haddr, stat) : rdat_r;
    ctrl_nxt   = ctrl_r;
    uvdly_nxt  = uvdly_r;
    if (dp_wr_r && dp_adr_r == OFS_CTRL) begin
      ctrl_nxt = hwdata[3:0];
    end
    if (dp_wr_r && dp_adr_r == OFS_UVDLY) begin
      uvdly_nxt = hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r  <= 1'b0;
      dp_adr_r <= 8'h00;
      rdat_r   <= 32'h0000_0000;
      ctrl_r   <= CTRL_RST;
      uvdly_r  <= UVDLY_RST;
    end else begin
      dp_wr_r  <= dp_wr_nxt;
      dp_adr_r <= dp_adr_nxt;
      rdat_r   <= rdat_nxt;
      ctrl_r   <= ctrl_nxt;
      uvdly_r  <= uvdly_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdat_r;

  tup_ov_window #(.PER(PER), .REL(REL)) i_tup_ov_window (
    .hclk    (hclk),
    .hresetn (hresetn),
    .req     (ovts && ov_fault),
    .pull_r  (pull)
  );
  assign thermistor_sense_o  = 1'b0;
  assign thermistor_sense_oe = pull;

  // Comparator flags registered; charger sense blind while pulling down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lr_r <= 1'b0;
      cd_r <= 1'b0;
    end else begin
      lr_r <= discharge_pack_neg_sense_below_2v;
      cd_r <= charger_sense_in && !pull;
    end
  end
  assign load_removed     = lr_r;
  assign charger_detected = cd_r && !pull;

  // Thermistor check sequence; not started while the line is forced low,
  // otherwise the pulldown itself would read as a shorted thermistor
  always_comb begin
    ck_nxt     = ck_r;
    tf_nxt     = tf_r;
    ext_nxt    = ext_r;
    ck_cnt_nxt = ck_cnt_r + 1'b1;
    unique case (ck_r)
      CK_IDLE: begin
        if (ck_cnt_r >= CNT_W'(CHK - 1)) begin
          ck_cnt_nxt = '0;
          if (!tmdis && !pull && !sd_r) begin
            ck_nxt = CK_SINK;
          end
        end
      end
      CK_SINK: begin
        if (ck_cnt_r == CNT_W'(SETTLE_CYC - 1)) begin
          ext_nxt    = ts_above_ext_pu;
          ck_cnt_nxt = '0;
          ck_nxt     = CK_BIAS;
        end
      end
      CK_BIAS: begin
        if (ck_cnt_r == CNT_W'(SETTLE_CYC - 1)) begin
          ck_cnt_nxt = '0;
          ck_nxt     = CK_EVAL;
        end
      end
      CK_EVAL: begin
        // open clears on a clean check
        if (ts_below_short) begin
          tf_nxt = TF_SHORT;
        end else if (ts_above_open) begin
          tf_nxt = TF_OPEN;
        end else if (ts_below_hot) begin
          tf_nxt = TF_HOT;
        end else begin
          tf_nxt = TF_NONE;
        end
        ck_cnt_nxt = '0;
        ck_nxt     = CK_IDLE;
      end
    endcase
    if (tmdis || sd_r || uvsd_hit) begin
      tf_nxt = TF_NONE;
    end
    if (sd_r || (tmdis && ck_r != CK_IDLE)) begin
      ck_nxt     = CK_IDLE;
      ck_cnt_nxt = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_r     <= CK_IDLE;
      tf_r     <= TF_NONE;
      ext_r    <= 1'b0;
      ck_cnt_r <= '0;
    end else begin
      ck_r     <= ck_nxt;
      tf_r     <= tf_nxt;
      ext_r    <= ext_nxt;
      ck_cnt_r <= ck_cnt_nxt;
    end
  end

  assign ts_weak_sink_en = ck_r != CK_IDLE;
  assign thermistor_bias_out = (ck_r == CK_BIAS || ck_r == CK_EVAL) && !ext_r;

  assign short_hit = ck_r == CK_EVAL && ts_below_short && !tmdis && !sd_r;
  // no shutdown when delay bit clear
  assign uvsd_hit  = uv_r && uvsd && cells_below_hyst && sd_cnt_r == CNT_W'(UVSD - 1);

  // Undervoltage fault, shutdown and power state
  always_comb begin
    uv_cnt_nxt = '0;
    sd_cnt_nxt = '0;
    uv_nxt     = uv_r;
    if (!uv_r && cell_uv_any) begin
      uv_cnt_nxt = uv_cnt_r + 1'b1;
      if (uv_cnt_r >= uvdly_r) begin
        uv_nxt     = 1'b1;
        uv_cnt_nxt = '0;
      end
    end
    if (uv_r && cells_above_hyst && (!uvrec || lr_r)) begin
      uv_nxt = 1'b0;
    end
    if (uv_r && uvsd && cells_below_hyst) begin
      sd_cnt_nxt = sd_cnt_r + 1'b1;
    end
    if (sd_r) begin
      sd_nxt = !charger_detected;
      uv_nxt = 1'b0;
    end else begin
      sd_nxt = short_hit || uvsd_hit;
    end
    reg_nxt = !sd_nxt;
    dsg_nxt = reg_nxt && tf_nxt == TF_NONE && !uv_nxt;
    chg_nxt = reg_nxt && tf_nxt == TF_NONE;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uv_cnt_r <= 32'h0000_0000;
      sd_cnt_r <= '0;
      uv_r     <= 1'b0;
      sd_r     <= 1'b0;
      reg_r    <= 1'b0;
      dsg_r    <= 1'b0;
      chg_r    <= 1'b0;
    end else begin
      uv_cnt_r <= uv_cnt_nxt;
      sd_cnt_r <= sd_cnt_nxt;
      uv_r     <= uv_nxt;
      sd_r     <= sd_nxt;
      reg_r    <= reg_nxt;
      dsg_r    <= dsg_nxt;
      chg_r    <= chg_nxt;
    end
  end

  assign regulator_output_en  = reg_r;
  assign discharge_gate_drive = dsg_r;
  assign charge_gate_drive    = chg_r;
  assign shutdown             = sd_r;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_BIAS_EXT: assert property (ext_r |-> !thermistor_bias_out)
    else $error("bias on with external source");
  AST_EXT_SAMPLE: assert property (ck_r == CK_SINK && ck_nxt == CK_BIAS ##1 1
      |-> ext_r == $past(ts_above_ext_pu) && ts_weak_sink_en)
    else $error("external bias not sampled");
  AST_HOT_GATES: assert property (tf_r == TF_HOT |-> !charge_gate_drive && !discharge_gate_drive
      && regulator_output_en)
    else $error("gates on during overtemperature");
  AST_SHORT_SD: assert property (short_hit |=> shutdown && !regulator_output_en)
    else $error("short did not shut down");
  AST_OPEN_PRIO: assert property (ck_r == CK_EVAL && ts_above_open && !ts_below_short
      && !tmdis && !sd_r |=> tf_r == TF_OPEN)
    else $error("open fault not latched");
  AST_PULL_CHG: assert property (thermistor_sense_oe |-> !charger_detected)
    else $error("charger sensed while pulling");
  AST_UV_DSG: assert property (uv_r |-> !discharge_gate_drive)
    else $error("discharge on with undervoltage");
  AST_UV_REC0: assert property (uv_r && !uvrec && cells_above_hyst |=> !uv_r)
    else $error("mode 0 recovery missed");
  AST_UV_REC1: assert property (uv_r && uvrec && !lr_r && !sd_r |=> uv_r)
    else $error("mode 1 cleared without load removal");
  AST_NO_UVSD: assert property (!uvsd && !short_hit && !sd_r |=> !sd_r)
    else $error("shutdown without delay bit");
  AST_SD_HOLD: assert property (sd_r && !charger_detected |=> sd_r)
    else $error("shutdown left without charger");
  AST_REG_GATES: assert property (!regulator_output_en |-> !discharge_gate_drive
      && !charge_gate_drive)
    else $error("gates on with regulator off");

  COV_HOT: cover property (ck_r == CK_EVAL ##1 tf_r == TF_HOT);
  COV_UV_SD: cover property (uv_r ##1 sd_r ##[1:20] !sd_r);
  COV_EXT: cover property (ext_r && ck_r == CK_EVAL);
endmodule

//--- tb/tup_partner.sv
// Charger and pack load model on the far side of the protector
`timescale 1ns/1ps
module tup_partner (
  input  wire logic hclk,             // Clock
  input  wire logic plug,             // Charger inserted
  input  wire logic load,             // Load attached
  input  wire logic pulled,           // Sense line held low
  output logic      charger_sense_in, // Charger comparator
  output logic      ts_above_ext_pu,  // Charger bias seen
  output logic      discharge_pack_neg_sense_below_2v    // Pack negative low
);
  // charger insertion wakes
  // Charger bias cannot lift a line that is pulled to ground;
  // outputs settle at the first edge, well inside reset
  always @(posedge hclk) begin
    charger_sense_in <= plug;
    ts_above_ext_pu  <= plug & ~pulled;
    discharge_pack_neg_sense_below_2v   <= ~load;
  end
endmodule

//--- tb/tup_protect_tb.sv
// Self-checking bench for the protection block
`timescale 1ns/1ps
module tup_protect_tb;
  import tup_pkg::*;
  localparam int unsigned CHK = 64;
  localparam int unsigned PER = 400;
  localparam int unsigned REL = 20;
  localparam int unsigned UVSD = 80;
  localparam int unsigned TCK = 2 * CHK + 80;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic        hreadyout, hresp, hot = 0, open = 0, shrt = 0;
  logic        uv = 0, above = 1, below = 0, ovf = 0, plug = 0, load = 1;
  logic        chs, ext, dpk, sink, bias, ts_o, oe, chd, ldr, reg_en, dg, cg, sd;
  logic        oe_q = 0, bias_seen = 0, sink_seen = 0;
  int          err_total = 0, n_tests = 0, cyc_n = 0, n;

  always #4 hclk = ~hclk;

  tup_protect #(.CHK(CHK), .PER(PER), .REL(REL), .UVSD(UVSD)) i_tup_protect (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ts_above_ext_pu(ext),
    .ts_below_hot(hot), .ts_above_open(open), .ts_below_short(shrt),
    .charger_sense_in(chs), .discharge_pack_neg_sense_below_2v(dpk), .cell_uv_any(uv),
    .cells_above_hyst(above), .cells_below_hyst(below), .ov_fault(ovf),
    .ts_weak_sink_en(sink), .thermistor_bias_out(bias), .thermistor_sense_o(ts_o),
    .thermistor_sense_oe(oe), .charger_detected(chd), .load_removed(ldr),
    .regulator_output_en(reg_en), .discharge_gate_drive(dg), .charge_gate_drive(cg),
    .shutdown(sd));

  tup_partner i_tup_partner (.hclk(hclk), .plug(plug), .load(load), .pulled(oe),
    .charger_sense_in(chs), .ts_above_ext_pu(ext), .discharge_pack_neg_sense_below_2v(dpk));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Sample at the falling edge, clear of the launching edge
  task automatic wt(input int c);
    repeat (c) @(posedge hclk);
    @(negedge hclk);
  endtask

  // Single word transfer; read data taken at the edge ending the data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic final_report;
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchers at the falling edge, clear of register updates, plus the hang limit
  always @(negedge hclk) begin
    oe_q <= oe;
    if (bias === 1'b1) bias_seen = 1;
    if (sink === 1'b1) sink_seen = 1;
    if (oe_q === 1'b1 && oe === 1'b1) chk(chd, 0);
    if (hresetn && reg_en === 1'b0) chk({dg, cg}, 0);
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      final_report();
    end
  end

  task automatic t_regs;
    bus(0, OFS_CTRL, 0); chk(q, CTRL_RST);
    bus(0, OFS_UVDLY, 0); chk(q, UVDLY_RST);
    bus(0, 8'h0c, 0); chk(q, 0);
    chk(hresp, 0);
    bus(1, OFS_CTRL, 32'hffffffff); bus(0, OFS_CTRL, 0); chk(q, 32'hf);
    bus(1, OFS_CTRL, 0);
  endtask

  task automatic t_bias;
    @(posedge hclk); plug <= 1;
    wt(TCK); bias_seen = 0; sink_seen = 0;
    wt(TCK);
    chk(bias_seen, 0);
    chk(sink_seen, 1);
    bus(0, OFS_STAT, 0); chk(q[5], 1);
    @(posedge hclk); plug <= 0;
    wt(TCK); bias_seen = 0;
    wt(TCK); chk(bias_seen, 1);
  endtask

  // Hot, then open with hot, then short with both: priority and actions
  task automatic t_temp;
    for (int i = 0; i < 3; i++) begin
      @(posedge hclk); hot <= 1; open <= (i > 0); shrt <= (i == 2);
      wt(TCK); chk({dg, cg}, 0);
      chk(sd, i == 2);
      if (i < 2) begin
        bus(0, OFS_STAT, 0); chk(q[1:0], i + 1);
        chk(reg_en, 1);
        @(posedge hclk); hot <= 0; open <= 0;
        wt(TCK); chk({dg, cg}, 2'h3);
      end
    end
    chk(reg_en, 0);
    @(posedge hclk); hot <= 0; open <= 0; shrt <= 0;
    wt(TCK); chk(sd, 1);
    @(posedge hclk); plug <= 1;
    wt(4); chk({sd, chd, reg_en}, 3'h3);
    @(posedge hclk); plug <= 0;
  endtask

  task automatic t_uv;
    bus(1, OFS_UVDLY, 8); bus(1, OFS_CTRL, 4);
    @(posedge hclk); uv <= 1; below <= 1; above <= 0;
    wt(5); chk(dg, 1);
    wt(10); chk({dg, cg}, 2'h1);
    wt(UVSD + 40); chk(sd, 0);
    @(posedge hclk); uv <= 0; below <= 0; above <= 1;
    wt(10); chk(dg, 0);
    @(posedge hclk); load <= 0;
    wt(5); chk({ldr, dg}, 2'h3);
    @(posedge hclk); load <= 1;
    bus(1, OFS_CTRL, 0);
    @(posedge hclk); uv <= 1; above <= 0;
    wt(15); chk(dg, 0);
    @(posedge hclk); uv <= 0; above <= 1;
    wt(4); chk(dg, 1);
    bus(1, OFS_CTRL, 8);
    @(posedge hclk); uv <= 1; below <= 1; above <= 0;
    wt(UVSD / 2); chk(sd, 0);
    wt(UVSD); chk({sd, reg_en}, 2'h2);
    @(posedge hclk); uv <= 0; below <= 0; above <= 1; plug <= 1;
    wt(4); chk(sd, 0);
    @(posedge hclk); plug <= 0;
    bus(1, OFS_CTRL, 0);
  endtask

  // Pulldown with monitoring disabled, then one release window measured
  task automatic t_ov;
    bus(1, OFS_CTRL, 3);
    @(posedge hclk); ovf <= 1; plug <= 1;
    wt(4); chk({oe, ts_o}, 2'h2);
    n = 0;
    while (oe === 1'b1 && n < 2 * PER) begin wt(1); n++; end
    n = 0;
    while (oe !== 1'b1 && n < 3 * REL) begin
      if (n == REL / 2) chk(chd, 1);
      wt(1); n++;
    end
    chk(n, REL);
    @(posedge hclk); ovf <= 0; plug <= 0;
    wt(4); chk(oe, 0);
    bus(1, OFS_CTRL, 0);
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    wt(2); chk({reg_en, dg, cg}, 3'h7);
    t_regs;
    t_bias;
    t_temp;
    t_uv;
    t_ov;
    final_report;
  end
endmodule
